//--- verilog/mscr_regs.sv
// mode and supply control register bank with its serial access port
// What this block does
// - mode field selects normal, sleep, stop, soft reset
// - bit 5 switches pnp regulator on
// - aux field selects when aux regulator runs
// - overvoltage reaction bit enables restart request
// - threshold field selects one of four levels
// - stop to sleep write is not accepted
// - restart rewrites mode field to normal
// - restart or overtemperature turns aux field off
// - write frame returns value before the write
// - mode register reset and restart values
// - config register restart and reset values
// - voltage select picks alternate pnp output
// - mask bit stops reset pin on soft reset
// - force bit activates failure outputs by software
// - undervoltage disables pnp unless keep bit set
// - load sharing bit runs pnp with main
// - config bit 2 reserved, reads zero
// - sharing-in-stop bit keeps pnp on in stop
// - config bit 0 picks first or second failure
// - sixteen-bit frame: address, access bit, data
// - restart clears force bit and failure outputs unless failure condition is active
// - soft reset keeps voltage select and sharing
module mscr_regs
   import mscr_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       sclk,
   input  wire logic       csn,
   input  wire logic       sdi,
   output logic            sdo,
   output logic            sdoOeN,
   input  wire logic       restartEnter,
   input  wire logic       overtemperature,
   input  wire logic       failSafeActive,
   input  wire logic       highPowerMode,
   input  wire logic       supplyUndervoltage,
   input  wire logic       mainOvervoltage,
   input  wire logic       failureCondition,
   input  wire logic       wdTriggerFail,
   output logic      [1:0] modeSelect,
   output logic            softResetReq,
   output logic            resetOutputPull,
   output logic            auxRegulatorOn,
   output logic            pnpRegulatorOn,
   output logic            pnpVoltageAlt,
   output logic            pnpLoadShare,
   output logic            overvoltageFlagSet,
   output logic            overvoltageRestartReq,
   output logic      [1:0] mainResetThreshold,
   output logic            failureOutputsOn,
   output logic            watchdogEscalate
);

   // ----------------------------------------------------------------
   // frame port
   // ----------------------------------------------------------------
   logic [7:0]  modeSupply_reg;
   logic [7:0]  hwConfig_reg;
   logic [7:0]  modeSupply_next;
   logic [7:0]  hwConfig_next;
   logic [6:0]  addr;
   logic        wrBit;
   logic [7:0]  wrData;
   logic        addrValid;
   logic        frameDone;
   logic [7:0]  readData;
   logic        wrMode;
   logic        wrHw;
   logic        softTrig;
   logic [1:0]  curMode;
   logic [1:0]  auxField;
   logic        ovPrev_reg;
   logic [1:0]  wdFailCnt_reg;
   logic [1:0]  wdLimit;

   mscr_spi_frame u_frame (
      .clock     (clock),
      .nrst      (nrst),
      .sclk      (sclk),
      .csn       (csn),
      .sdi       (sdi),
      .readData  (readData),
      .addr      (addr),
      .wrBit     (wrBit),
      .wrData    (wrData),
      .addrValid (addrValid),
      .frameDone (frameDone),
      .sdo       (sdo),
      .sdoOeN    (sdoOeN)
   );

   // read data captured mid-frame, before any write takes effect
   always_comb begin
      case (addr)
         ADDR_MODE_SUPPLY: readData = modeSupply_reg;
         ADDR_HW_SUPPLY:   readData = hwConfig_reg & HW_WRITE_MASK;
         default:          readData = 8'h00;
      endcase
   end

   assign wrMode   = frameDone & wrBit & (addr == ADDR_MODE_SUPPLY);
   assign wrHw     = frameDone & wrBit & (addr == ADDR_HW_SUPPLY);
   assign softTrig = wrMode & (wrData[MODE_HI:MODE_LO] == MODE_SOFT_RESET);
   assign curMode  = modeSupply_reg[MODE_HI:MODE_LO];
   assign auxField = modeSupply_reg[AUX_HI:AUX_LO];

   // ----------------------------------------------------------------
   // mode_supply_control
   // ----------------------------------------------------------------
   always_comb begin
      modeSupply_next = modeSupply_reg;
      if (restartEnter) begin
         modeSupply_next = modeSupply_reg & MSC_RESTART_KEEP;
      end else if (softTrig) begin
         modeSupply_next = MSC_POR;
      end else if (wrMode) begin
         modeSupply_next = wrData;
         if (curMode == MODE_STOP && wrData[MODE_HI:MODE_LO] == MODE_SLEEP) begin
            modeSupply_next[MODE_HI:MODE_LO] = MODE_STOP;
         end
      end
      if (overtemperature) begin
         modeSupply_next[AUX_HI:AUX_LO] = AUX_OFF;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         modeSupply_reg <= MSC_POR;
      end else begin
         modeSupply_reg <= modeSupply_next;
      end
   end

   // ----------------------------------------------------------------
   // hardware_supply_config
   // ----------------------------------------------------------------
   always_comb begin
      hwConfig_next = hwConfig_reg;
      if (restartEnter) begin
         hwConfig_next = hwConfig_reg & HW_RESTART_KEEP;
      end else if (softTrig) begin
         hwConfig_next = hwConfig_reg & HW_SOFT_KEEP;
      end else if (wrHw) begin
         hwConfig_next = wrData & HW_WRITE_MASK;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         hwConfig_reg <= HW_POR;
      end else begin
         hwConfig_reg <= hwConfig_next;
      end
   end

   // ----------------------------------------------------------------
   // soft reset requests
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         softResetReq    <= 1'b0;
         resetOutputPull <= 1'b0;
      end else begin
         softResetReq    <= softTrig & ~restartEnter;
         resetOutputPull <= softTrig & ~restartEnter & ~hwConfig_reg[SR_MASK_POS];
      end
   end

   // ----------------------------------------------------------------
   // regulator controls
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         auxRegulatorOn <= 1'b0;
      end else begin
         case (auxField)
            AUX_OFF:         auxRegulatorOn <= 1'b0;
            AUX_NORMAL:      auxRegulatorOn <= (curMode == MODE_NORMAL);
            AUX_NORMAL_STOP: auxRegulatorOn <= (curMode == MODE_NORMAL) | (curMode == MODE_STOP);
            AUX_ALWAYS:      auxRegulatorOn <= ~failSafeActive;
            default:         auxRegulatorOn <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pnpRegulatorOn <= 1'b0;
         pnpVoltageAlt  <= 1'b0;
         pnpLoadShare   <= 1'b0;
      end else begin
         pnpRegulatorOn <= modeSupply_reg[PNP_EN_POS]
            & ~(supplyUndervoltage & ~hwConfig_reg[PNP_KEEP_UV_POS])
            & ~(hwConfig_reg[PNP_LS_POS] & ~hwConfig_reg[PNP_LS_STOP_POS]
                & ((curMode == MODE_STOP) | highPowerMode));
         pnpVoltageAlt  <= hwConfig_reg[PNP_VSEL_POS];
         pnpLoadShare   <= hwConfig_reg[PNP_LS_POS];
      end
   end

   // ----------------------------------------------------------------
   // main regulator supervision
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ovPrev_reg            <= 1'b0;
         overvoltageFlagSet    <= 1'b0;
         overvoltageRestartReq <= 1'b0;
         mainResetThreshold    <= 2'h0;
         modeSelect            <= MODE_NORMAL;
      end else begin
         ovPrev_reg            <= mainOvervoltage;
         overvoltageFlagSet    <= mainOvervoltage & ~ovPrev_reg;
         overvoltageRestartReq <= mainOvervoltage & ~ovPrev_reg
                                  & modeSupply_reg[OV_REACT_POS];
         mainResetThreshold    <= modeSupply_reg[RT_HI:RT_LO];
         modeSelect            <= curMode;
      end
   end

   // ----------------------------------------------------------------
   // failure outputs and watchdog escalation
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         failureOutputsOn <= 1'b0;
      end else begin
         failureOutputsOn <= hwConfig_reg[FO_FORCE_POS] | failureCondition;
      end
   end

   assign wdLimit = hwConfig_reg[WD_CFG_POS] ? WD_LIMIT_FIRST : WD_LIMIT_SECOND;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wdFailCnt_reg    <= 2'h0;
         watchdogEscalate <= 1'b0;
      end else begin
         watchdogEscalate <= 1'b0;
         if (restartEnter || softTrig) begin
            wdFailCnt_reg <= 2'h0;
         end else if (wdTriggerFail) begin
            if (wdFailCnt_reg + 2'h1 >= wdLimit) begin
               wdFailCnt_reg    <= 2'h0;
               watchdogEscalate <= 1'b1;
            end else begin
               wdFailCnt_reg <= wdFailCnt_reg + 2'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   a_mode_restart: assert property (restartEnter |=> curMode == MODE_NORMAL)
      else $error("mode not normal after restart");
   a_aux_clear: assert property ((restartEnter || overtemperature) |=> auxField == AUX_OFF)
      else $error("aux field not off");
   a_stop_sleep: assert property (wrMode && !restartEnter && curMode == MODE_STOP
      && wrData[MODE_HI:MODE_LO] == MODE_SLEEP |=> curMode == MODE_STOP)
      else $error("stop to sleep accepted");
   a_rsvd_zero: assert property (!hwConfig_reg[HW_RSVD_POS] && (addr != ADDR_HW_SUPPLY || !readData[HW_RSVD_POS]))
      else $error("reserved bit set");
   a_restart_keep: assert property (restartEnter |=> modeSupply_reg[PNP_EN_POS] == $past(modeSupply_reg[PNP_EN_POS])
      && modeSupply_reg[RT_HI:RT_LO] == $past(modeSupply_reg[RT_HI:RT_LO]) && !modeSupply_reg[OV_REACT_POS])
      else $error("restart value wrong");
   a_soft_reset: assert property (softTrig && !restartEnter |=> modeSupply_reg[7:3] == 5'h00 && softResetReq
      && hwConfig_reg == ($past(hwConfig_reg) & HW_SOFT_KEEP))
      else $error("soft reset value wrong");
   a_reset_pin: assert property (softResetReq |-> resetOutputPull == !$past(hwConfig_reg[SR_MASK_POS]))
      else $error("reset pin request wrong");
   a_fo_restart: assert property (restartEnter ##1 !failureCondition |=> !failureOutputsOn)
      else $error("failure outputs kept after restart");
   a_hw_frame_only: assert property ($changed(hwConfig_reg) |-> $past(wrHw || softTrig || restartEnter))
      else $error("config changed without frame");
   a_wd_first: assert property (wdTriggerFail && hwConfig_reg[WD_CFG_POS] && !restartEnter
      && !softTrig |=> watchdogEscalate)
      else $error("no escalation on first failure");
   a_pnp_uv: assert property (supplyUndervoltage && !hwConfig_reg[PNP_KEEP_UV_POS] |=> !pnpRegulatorOn)
      else $error("pnp on during undervoltage");

   c_restart: cover property (restartEnter ##1 curMode == MODE_NORMAL);
   c_soft_reset: cover property (softTrig ##1 resetOutputPull);
   c_stop_sleep: cover property (wrMode && curMode == MODE_STOP && wrData[MODE_HI:MODE_LO] == MODE_SLEEP);
   c_read_frame: cover property (frameDone && !wrBit && addr == ADDR_HW_SUPPLY);

endmodule

//--- verilog/mscr_pkg.sv
// constants and types shared by the mode and supply control register bank
package mscr_pkg;

   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam int          FRAME_BITS       = 16;
   localparam int          ADDR_BITS        = 7;
   localparam int          WR_BIT_POS       = 7;
   localparam logic [4:0]  FRAME_BITS_CNT   = 5'h10;
   localparam logic [4:0]  ADDR_BYTE_CNT    = 5'h08;
   localparam logic [4:0]  BIT_CNT_MAX      = 5'h1F;
   localparam logic [7:0]  FIRST_BYTE_OUT   = 8'h00;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [6:0]  ADDR_MODE_SUPPLY = 7'h01;
   localparam logic [6:0]  ADDR_HW_SUPPLY   = 7'h02;

   // ----------------------------------------------------------------
   // mode_supply_control fields
   // ----------------------------------------------------------------
   localparam int          MODE_HI          = 7;
   localparam int          MODE_LO          = 6;
   localparam int          PNP_EN_POS       = 5;
   localparam int          AUX_HI           = 4;
   localparam int          AUX_LO           = 3;
   localparam int          OV_REACT_POS     = 2;
   localparam int          RT_HI            = 1;
   localparam int          RT_LO            = 0;

   // ----------------------------------------------------------------
   // hardware_supply_config fields
   // ----------------------------------------------------------------
   localparam int          PNP_VSEL_POS     = 7;
   localparam int          SR_MASK_POS      = 6;
   localparam int          FO_FORCE_POS     = 5;
   localparam int          PNP_KEEP_UV_POS  = 4;
   localparam int          PNP_LS_POS       = 3;
   localparam int          HW_RSVD_POS      = 2;
   localparam int          PNP_LS_STOP_POS  = 1;
   localparam int          WD_CFG_POS       = 0;

   // ----------------------------------------------------------------
   // reset values and keep masks
   // ----------------------------------------------------------------
   localparam logic [7:0]  MSC_POR          = 8'h00;
   localparam logic [7:0]  MSC_RESTART_KEEP = 8'h23;
   localparam logic [7:0]  HW_POR           = 8'h00;
   localparam logic [7:0]  HW_SOFT_KEEP     = 8'h88;
   localparam logic [7:0]  HW_RESTART_KEEP  = 8'hD9;
   localparam logic [7:0]  HW_WRITE_MASK    = 8'hFB;

   // ----------------------------------------------------------------
   // field codes
   // ----------------------------------------------------------------
   localparam logic [1:0]  MODE_NORMAL      = 2'h0;
   localparam logic [1:0]  MODE_SLEEP       = 2'h1;
   localparam logic [1:0]  MODE_STOP        = 2'h2;
   localparam logic [1:0]  MODE_SOFT_RESET  = 2'h3;
   localparam logic [1:0]  AUX_OFF          = 2'h0;
   localparam logic [1:0]  AUX_NORMAL       = 2'h1;
   localparam logic [1:0]  AUX_NORMAL_STOP  = 2'h2;
   localparam logic [1:0]  AUX_ALWAYS       = 2'h3;
   localparam logic [1:0]  WD_LIMIT_SECOND  = 2'h2;
   localparam logic [1:0]  WD_LIMIT_FIRST   = 2'h1;

   typedef enum logic [2:0] {
      SPI_IDLE = 3'h1,
      SPI_ADDR = 3'h2,
      SPI_DATA = 3'h4
   } mscr_spi_state_t;

endpackage

//--- verilog/mscr_spi_frame.sv
// serial frame receiver and transmitter for the register bank
module mscr_spi_frame
   import mscr_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       sclk,
   input  wire logic       csn,
   input  wire logic       sdi,
   input  wire logic [7:0] readData,
   output logic      [6:0] addr,
   output logic            wrBit,
   output logic      [7:0] wrData,
   output logic            addrValid,
   output logic            frameDone,
   output logic            sdo,
   output logic            sdoOeN
);

   mscr_spi_state_t  state_reg;
   logic             sclkPrev_reg;
   logic             csnPrev_reg;
   logic [4:0]       bitCnt_reg;
   logic [15:0]      shiftIn_reg;
   logic [15:0]      shiftOut_reg;
   logic             sclkRise;
   logic             sclkFall;
   logic             csnFall;
   logic             csnRise;

   assign sclkRise = sclk & ~sclkPrev_reg & ~csn;
   assign sclkFall = ~sclk & sclkPrev_reg & ~csn;
   assign csnFall  = ~csn & csnPrev_reg;
   assign csnRise  = csn & ~csnPrev_reg;
   // first byte: address in bits 0..6, access bit in bit 7
   // address sits high mid-frame, low once chip select rises and the receiver is back in idle
   assign addr     = (state_reg == SPI_IDLE) ? shiftIn_reg[6:0] : shiftIn_reg[14:8];
   assign wrBit    = (state_reg == SPI_ADDR) ? shiftIn_reg[15] : shiftIn_reg[WR_BIT_POS];
   assign wrData   = shiftIn_reg[15:8];

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sclkPrev_reg <= 1'b0;
         csnPrev_reg  <= 1'b1;
      end else begin
         sclkPrev_reg <= sclk;
         csnPrev_reg  <= csn;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg  <= SPI_IDLE;
         bitCnt_reg <= 5'h00;
         addrValid  <= 1'b0;
         frameDone  <= 1'b0;
      end else begin
         addrValid <= 1'b0;
         frameDone <= 1'b0;
         case (state_reg)
            SPI_IDLE: begin
               bitCnt_reg <= 5'h00;
               if (csnFall) begin
                  state_reg <= SPI_ADDR;
               end
            end
            SPI_ADDR: begin
               if (csnRise) begin
                  state_reg <= SPI_IDLE;
               end else if (sclkRise) begin
                  bitCnt_reg <= bitCnt_reg + 5'h01;
                  if (bitCnt_reg == ADDR_BYTE_CNT - 5'h01) begin
                     state_reg <= SPI_DATA;
                     addrValid <= 1'b1;
                  end
               end
            end
            SPI_DATA: begin
               if (csnRise) begin
                  state_reg <= SPI_IDLE;
                  frameDone <= (bitCnt_reg == FRAME_BITS_CNT);
               end else if (sclkRise && bitCnt_reg != BIT_CNT_MAX) begin
                  bitCnt_reg <= bitCnt_reg + 5'h01;
               end
            end
            default: begin
               state_reg <= SPI_IDLE;
            end
         endcase
      end
   end

   // lsb first, sampled on rising, shifted out on falling
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         shiftIn_reg  <= 16'h0000;
         shiftOut_reg <= 16'h0000;
      end else begin
         if (sclkRise) begin
            shiftIn_reg <= {sdi, shiftIn_reg[15:1]};
         end
         if (state_reg == SPI_IDLE && csnFall) begin
            shiftOut_reg <= {8'h00, FIRST_BYTE_OUT};
         end else if (addrValid) begin
            shiftOut_reg[8:1] <= readData;
         end else if (sclkFall) begin
            shiftOut_reg <= {1'b0, shiftOut_reg[15:1]};
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sdo    <= 1'b0;
         sdoOeN <= 1'b1;
      end else begin
         sdo    <= shiftOut_reg[0];
         sdoOeN <= csn;
      end
   end

endmodule

//--- test/mscr_spi_master.sv
// serial master model standing in for the microcontroller
module mscr_spi_master (
   output logic      sclk,
   output logic      csn,
   output logic      sdi,
   input  wire logic clock,
   input  wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      sclk = 1'b0;
      csn  = 1'b1;
      sdi  = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge clock);
   endtask

   // lsb-first frame of n rises, second byte taken from sdo
   task automatic xfer(input logic [15:0] f, input int n, output logic [7:0] rd);
      rd = 8'h00;
      @(posedge clock);
      csn <= 1'b0;
      for (int i = 0; i < n; i++) begin
         sdi <= f[i];
         hold(3);
         if (i >= 8) begin
            rd[i-8] = sdo;
         end
         sclk <= 1'b1;
         hold(3);
         sclk <= 1'b0;
      end
      hold(3);
      csn <= 1'b1;
      // released line must not keep its last value
      sdi <= ~sdi;
      hold(6);
   endtask
endmodule

//--- test/mscr_regs_tb.sv
// self-checking bench for the mode and supply control register bank
module mscr_regs_tb;
   import mscr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clock = 1'b0, nrst = 1'b0, sclk, csn, sdi, sdo, sdoOeN;
   logic       restartEnter = 1'b0, overtemperature = 1'b0, failSafeActive = 1'b0;
   logic       highPowerMode = 1'b0, supplyUndervoltage = 1'b0, mainOvervoltage = 1'b0;
   logic       failureCondition = 1'b0, wdTriggerFail = 1'b0;
   logic [1:0] modeSelect, mainResetThreshold;
   logic       softResetReq, resetOutputPull, auxRegulatorOn, pnpRegulatorOn, pnpVoltageAlt;
   logic       pnpLoadShare, overvoltageFlagSet, overvoltageRestartReq, failureOutputsOn;
   logic       watchdogEscalate;
   logic [7:0] nSoft = 8'h00, nPull = 8'h00, nEsc = 8'h00, nOvr = 8'h00, nOvf = 8'h00;
   logic [7:0] junk;
   int         err_total = 0;
   int         n_compared = 0;

   always #10 clock = ~clock;

   mscr_spi_master u_mscr_spi_master (.clock, .sclk, .csn, .sdi, .sdo);

   mscr_regs u_mscr_regs (.clock, .nrst, .sclk, .csn, .sdi, .sdo, .sdoOeN, .restartEnter,
      .overtemperature, .failSafeActive, .highPowerMode, .supplyUndervoltage, .mainOvervoltage,
      .failureCondition, .wdTriggerFail, .modeSelect, .softResetReq, .resetOutputPull,
      .auxRegulatorOn, .pnpRegulatorOn, .pnpVoltageAlt, .pnpLoadShare, .overvoltageFlagSet,
      .overvoltageRestartReq, .mainResetThreshold, .failureOutputsOn, .watchdogEscalate);

   // pulse counters
   always @(posedge clock) begin
      if (softResetReq === 1'b1) nSoft <= nSoft + 8'h01;
      if (resetOutputPull === 1'b1) nPull <= nPull + 8'h01;
      if (watchdogEscalate === 1'b1) nEsc <= nEsc + 8'h01;
      if (overvoltageRestartReq === 1'b1) nOvr <= nOvr + 8'h01;
      if (overvoltageFlagSet === 1'b1) nOvf <= nOvf + 8'h01;
   end

   task automatic results;
      if (err_total == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [7:0] old);
      logic [7:0] v;
      u_mscr_spi_master.xfer({d, 1'b1, a}, 16, v);
      chk("write echo", old, v);
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] v;
      u_mscr_spi_master.xfer({8'h00, 1'b0, a}, 16, v);
      chk("read", e, v);
   endtask

   task automatic wdFail;
      wdTriggerFail <= 1'b1;
      @(posedge clock);
      wdTriggerFail <= 1'b0;
      repeat (4) @(posedge clock);
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      results();
   end

   initial begin
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      repeat (2) @(posedge clock);
      rd(ADDR_MODE_SUPPLY, 8'h00);
      rd(ADDR_HW_SUPPLY, 8'h00);
      wr(ADDR_HW_SUPPLY, 8'hFF, 8'h00);
      rd(ADDR_HW_SUPPLY, 8'hFB);
      chk("pnpVoltageAlt", 8'h01, {7'h00, pnpVoltageAlt});
      chk("pnpLoadShare", 8'h01, {7'h00, pnpLoadShare});
      chk("failureOutputsOn", 8'h01, {7'h00, failureOutputsOn});
      u_mscr_spi_master.xfer({8'hFF, 1'b1, ADDR_MODE_SUPPLY}, 15, junk);
      rd(ADDR_MODE_SUPPLY, 8'h00);
      wr(7'h05, 8'hFF, 8'h00);
      rd(7'h05, 8'h00);
      wr(ADDR_MODE_SUPPLY, 8'h1F, 8'h00);
      chk("mainResetThreshold", 8'h03, {6'h00, mainResetThreshold});
      chk("auxRegulatorOn", 8'h01, {7'h00, auxRegulatorOn});
      chk("pnpRegulatorOn off", 8'h00, {7'h00, pnpRegulatorOn});
      wr(ADDR_MODE_SUPPLY, 8'h3F, 8'h1F);
      chk("pnpRegulatorOn on", 8'h01, {7'h00, pnpRegulatorOn});
      supplyUndervoltage <= 1'b1;
      repeat (4) @(posedge clock);
      chk("pnp kept on", 8'h01, {7'h00, pnpRegulatorOn});
      mainOvervoltage <= 1'b1;
      repeat (4) @(posedge clock);
      mainOvervoltage <= 1'b0;
      repeat (2) @(posedge clock);
      chk("ov flag pulses", 8'h01, nOvf);
      chk("ov restart pulses", 8'h01, nOvr);
      wr(ADDR_MODE_SUPPLY, 8'hBF, 8'h3F);
      chk("modeSelect stop", {6'h00, MODE_STOP}, {6'h00, modeSelect});
      wr(ADDR_MODE_SUPPLY, 8'h7F, 8'hBF);
      rd(ADDR_MODE_SUPPLY, 8'hBF);
      wr(ADDR_MODE_SUPPLY, 8'h3F, 8'hBF);
      wr(ADDR_MODE_SUPPLY, 8'h7F, 8'h3F);
      chk("modeSelect sleep", {6'h00, MODE_SLEEP}, {6'h00, modeSelect});
      overtemperature <= 1'b1;
      @(posedge clock);
      overtemperature <= 1'b0;
      repeat (3) @(posedge clock);
      rd(ADDR_MODE_SUPPLY, 8'h67);
      restartEnter <= 1'b1;
      @(posedge clock);
      restartEnter <= 1'b0;
      repeat (3) @(posedge clock);
      chk("failureOutputsOn", 8'h00, {7'h00, failureOutputsOn});
      rd(ADDR_MODE_SUPPLY, 8'h23);
      rd(ADDR_HW_SUPPLY, 8'hD9);
      wdFail();
      chk("escalate first", 8'h01, nEsc);
      wr(ADDR_MODE_SUPPLY, 8'hC0, 8'h23);
      rd(ADDR_MODE_SUPPLY, 8'h00);
      rd(ADDR_HW_SUPPLY, 8'h88);
      chk("soft reset pin masked", 8'h00, nPull);
      wr(ADDR_MODE_SUPPLY, 8'hC0, 8'h00);
      chk("soft resets", 8'h02, nSoft);
      chk("soft reset pin pulled", 8'h01, nPull);
      wdFail();
      chk("escalate not yet", 8'h01, nEsc);
      wdFail();
      chk("escalate second", 8'h02, nEsc);
      wr(ADDR_MODE_SUPPLY, 8'h20, 8'h00);
      chk("pnp off undervoltage", 8'h00, {7'h00, pnpRegulatorOn});
      supplyUndervoltage <= 1'b0;
      repeat (4) @(posedge clock);
      chk("pnp back on", 8'h01, {7'h00, pnpRegulatorOn});
      highPowerMode <= 1'b1;
      repeat (4) @(posedge clock);
      chk("pnp off high power", 8'h00, {7'h00, pnpRegulatorOn});
      highPowerMode <= 1'b0;
      failureCondition <= 1'b1;
      repeat (4) @(posedge clock);
      chk("failureOutputsOn condition", 8'h01, {7'h00, failureOutputsOn});
      failureCondition <= 1'b0;
      chk("sdoOeN idle", 8'h01, {7'h00, sdoOeN});
      wr(ADDR_MODE_SUPPLY, 8'h28, 8'h20);
      chk("aux normal only", 8'h01, {7'h00, auxRegulatorOn});
      results();
   end
endmodule
